// file: hdl/actirq_pkg.sv
// package: register offsets, field positions, modes and carriers
package actirq_pkg;
    // register select offsets (4-bit register select)
    localparam logic [3:0] REG_PORT_B    = 4'h0;
    localparam logic [3:0] REG_DIR_B     = 4'h2;
    localparam logic [3:0] REG_T1_LO     = 4'h4;
    localparam logic [3:0] REG_T1_HI     = 4'h5;
    localparam logic [3:0] REG_T1L_LO    = 4'h6;
    localparam logic [3:0] REG_T1L_HI    = 4'h7;
    localparam logic [3:0] REG_T2_LO     = 4'h8;
    localparam logic [3:0] REG_T2_HI     = 4'h9;
    localparam logic [3:0] REG_SHIFT     = 4'ha;
    localparam logic [3:0] REG_AUX       = 4'hb;
    localparam logic [3:0] REG_IFR       = 4'hd;
    localparam logic [3:0] REG_IER       = 4'he;
    // aux_mode_control fields
    localparam int AUX_LATCH_B    = 0;
    localparam int AUX_SHIFT_LO   = 2;
    localparam int AUX_T2_MODE    = 5;
    localparam int AUX_T1_FREE    = 6;
    localparam int AUX_T1_PIN     = 7;
    localparam logic [7:0] AUX_RESET = 8'h00;
    // interrupt flag positions
    localparam int IRQ_SHIFT    = 2;
    localparam int IRQ_CB1      = 4;
    localparam int IRQ_T2       = 5;
    localparam int IRQ_T1       = 6;
    localparam int IRQ_ANY      = 7;
    localparam int NUM_SOURCES  = 7;
    localparam int SHIFT_BITS   = 8;
    // shift register modes
    typedef enum logic [2:0] {
        SM_OFF      = 3'h0,
        SM_IN_T2    = 3'h1,
        SM_IN_SYS   = 3'h2,
        SM_IN_EXT   = 3'h3,
        SM_OUT_FREE = 3'h4,
        SM_OUT_T2   = 3'h5,
        SM_OUT_SYS  = 3'h6,
        SM_OUT_EXT  = 3'h7
    } actirq_shift_mode_e;
    // host bus request
    typedef struct packed {
        logic       sel;
        logic       wr;
        logic [3:0] addr;
        logic [7:0] data;
    } actirq_bus_s;
endpackage

// file: hdl/actirq_top.sv
// aux mode control, timers, shifter, port b latch and interrupt flags
module actirq_top #(
    parameter int SHIFT_LEN = 8
) (
    input  wire logic              sys_clk_i,
    input  wire logic              rst_n_i,
    input  wire actirq_pkg::actirq_bus_s bus_i,
    output logic [7:0]             rdata_o,
    input  wire logic [7:0]        port_b_pins_i,
    output logic [7:0]             port_b_out_o,
    output logic [7:0]             port_b_oe_o,
    input  wire logic              cb1_i,
    output logic                   cb1_o,
    output logic                   cb1_oe_o,
    input  wire logic              cb2_i,
    output logic                   cb2_o,
    output logic                   cb2_oe_o,
    input  wire logic [4:0]        other_flags_set_i,
    output logic                   irq_n_o
);
    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0]  aux_mode_control_q;
    logic [7:0]  port_b_output_reg_q;
    logic [7:0]  dir_b_q;
    logic [7:0]  latch_b_q;
    logic [15:0] t1_latch_q;
    logic [15:0] t1_cnt_q;
    logic        t1_run_q;
    logic        t1_pin_q;
    logic [7:0]  t2_latch_lo_q;
    logic [15:0] t2_cnt_q;
    logic        t2_run_q;
    logic [SHIFT_LEN-1:0] shifter_q;
    logic [3:0]  shift_cnt_q;
    logic        shift_run_q;
    logic        sclk_q;
    logic [6:0]  ifr_q;
    logic [6:0]  ier_q;
    logic        cb1_prev_q;
    logic        pb6_prev_q;

    logic wr;
    logic rd;
    logic t1_to;
    logic t2_to;
    logic cb1_fall;
    logic pb6_fall;
    logic shift_edge;
    logic shift_done;
    actirq_pkg::actirq_shift_mode_e smode;
    logic [6:0] set_flags;
    logic [6:0] clr_flags;

    assign wr = bus_i.sel && bus_i.wr;
    assign rd = bus_i.sel && !bus_i.wr;
    assign smode = actirq_pkg::actirq_shift_mode_e'(
        aux_mode_control_q[actirq_pkg::AUX_SHIFT_LO +: 3]);
    assign cb1_fall = cb1_prev_q && !cb1_i;
    assign pb6_fall = pb6_prev_q && !port_b_pins_i[6];
    assign t1_to = t1_run_q && (t1_cnt_q == 16'h0000);
    assign t2_to = t2_run_q && (t2_cnt_q == 16'h0000);

    // ------------------------------------------------------------
    // host writes to plain registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            aux_mode_control_q  <= actirq_pkg::AUX_RESET;
            port_b_output_reg_q <= 8'h00;
            dir_b_q             <= 8'h00;
            ier_q               <= 7'h00;
            t2_latch_lo_q       <= 8'h00;
        end else if (wr) begin
            if (bus_i.addr == actirq_pkg::REG_AUX) begin
                aux_mode_control_q <= bus_i.data;
            end else if (bus_i.addr == actirq_pkg::REG_PORT_B) begin
                port_b_output_reg_q <= bus_i.data;
            end else if (bus_i.addr == actirq_pkg::REG_DIR_B) begin
                dir_b_q <= bus_i.data;
            end else if (bus_i.addr == actirq_pkg::REG_T2_LO) begin
                t2_latch_lo_q <= bus_i.data;
            end else if (bus_i.addr == actirq_pkg::REG_IER) begin
                // bit 7 chooses set or clear of the named enables
                if (bus_i.data[7]) begin
                    ier_q <= ier_q | bus_i.data[6:0];
                end else begin
                    ier_q <= ier_q & ~bus_i.data[6:0];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // port b input latch
    // ------------------------------------------------------------
    logic [7:0] pb_mix;
    assign pb_mix = (port_b_pins_i & ~dir_b_q)
                  | (port_b_output_reg_q & dir_b_q);

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            latch_b_q <= 8'h00;
        end else if (!aux_mode_control_q[actirq_pkg::AUX_LATCH_B]) begin
            latch_b_q <= pb_mix;
        end else if (!ifr_q[actirq_pkg::IRQ_CB1]) begin
            // capture on the flag setting edge, then hold
            latch_b_q <= pb_mix;
        end
    end

    // ------------------------------------------------------------
    // timer one
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            t1_latch_q <= 16'hffff;
            t1_cnt_q   <= 16'hffff;
            t1_run_q   <= 1'b0;
            t1_pin_q   <= 1'b1;
        end else begin
            if (wr && (bus_i.addr == actirq_pkg::REG_T1_LO ||
                       bus_i.addr == actirq_pkg::REG_T1L_LO)) begin
                t1_latch_q[7:0] <= bus_i.data;
            end
            if (wr && bus_i.addr == actirq_pkg::REG_T1L_HI) begin
                t1_latch_q[15:8] <= bus_i.data;
            end
            if (wr && bus_i.addr == actirq_pkg::REG_T1_HI) begin
                t1_latch_q[15:8] <= bus_i.data;
                t1_cnt_q <= {bus_i.data, t1_latch_q[7:0]};
                t1_run_q <= 1'b1;
                t1_pin_q <= 1'b0;
            end else if (t1_to) begin
                if (aux_mode_control_q[actirq_pkg::AUX_T1_FREE]) begin
                    t1_cnt_q <= t1_latch_q;
                    t1_pin_q <= !t1_pin_q;
                end else begin
                    t1_run_q <= 1'b0;
                    t1_pin_q <= 1'b1;
                end
            end else begin
                t1_cnt_q <= t1_cnt_q - 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // timer two
    // ------------------------------------------------------------
    // in the timer two shift modes (SM_IN_T2, SM_OUT_T2, SM_OUT_FREE) the bit time comes from a divider reloaded from the low latch; this counter does not reload
    logic t2_pulse_mode;
    assign t2_pulse_mode = aux_mode_control_q[actirq_pkg::AUX_T2_MODE];

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            t2_cnt_q <= 16'hffff;
            t2_run_q <= 1'b0;
        end else if (wr && bus_i.addr == actirq_pkg::REG_T2_HI) begin
            t2_cnt_q <= {bus_i.data, t2_latch_lo_q};
            t2_run_q <= 1'b1;
        end else if (t2_to) begin
            t2_run_q <= 1'b0;
        end else if (!t2_pulse_mode || pb6_fall) begin
            t2_cnt_q <= t2_cnt_q - 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // shift register
    // ------------------------------------------------------------
    logic shift_out_mode;
    logic ext_mode;
    logic t2_mode;
    logic t2_bit;
    logic [7:0] t2_div_q;
    assign shift_out_mode = smode[2];
    assign ext_mode = (smode == actirq_pkg::SM_IN_EXT) ||
                      (smode == actirq_pkg::SM_OUT_EXT);
    assign t2_mode = (smode == actirq_pkg::SM_IN_T2) ||
                     (smode == actirq_pkg::SM_OUT_T2) ||
                     (smode == actirq_pkg::SM_OUT_FREE);
    assign t2_bit = (t2_div_q == 8'h00);

    // bit-time divider fed from timer two low latch, up to 256 cycles
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            t2_div_q <= 8'h00;
        end else if (t2_bit) begin
            t2_div_q <= t2_latch_lo_q;
        end else begin
            t2_div_q <= t2_div_q - 8'h01;
        end
    end

    always_comb begin
        shift_edge = 1'b0;
        if (smode == actirq_pkg::SM_OFF) begin
            shift_edge = 1'b0;
        end else if (ext_mode) begin
            shift_edge = cb1_fall;
        end else if (t2_mode) begin
            shift_edge = t2_bit;
        end else begin
            shift_edge = 1'b1;
        end
    end

    assign shift_done = shift_run_q && shift_edge &&
        (shift_cnt_q == 4'(SHIFT_LEN - 1)) &&
        (smode != actirq_pkg::SM_OUT_FREE);

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            shifter_q   <= '0;
            shift_cnt_q <= 4'h0;
            shift_run_q <= 1'b0;
            sclk_q      <= 1'b1;
        end else if (bus_i.sel && bus_i.addr == actirq_pkg::REG_SHIFT) begin
            // any access to the shifter restarts a transfer, SHIFT_LEN bits long except endless in SM_OUT_FREE, or stops it when the mode is off
            if (wr) begin
                shifter_q <= bus_i.data[SHIFT_LEN-1:0];
            end
            shift_cnt_q <= 4'h0;
            shift_run_q <= (smode != actirq_pkg::SM_OFF);
        end else if (shift_run_q && shift_edge) begin
            if (shift_out_mode) begin
                shifter_q <= {shifter_q[SHIFT_LEN-2:0],
                              shifter_q[SHIFT_LEN-1]};
            end else begin
                shifter_q <= {shifter_q[SHIFT_LEN-2:0], cb2_i};
            end
            sclk_q <= !sclk_q;
            shift_cnt_q <= shift_cnt_q + 4'h1;
            if (shift_done) begin
                shift_run_q <= 1'b0;
            end
        end else begin
            sclk_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // interrupt flags
    // ------------------------------------------------------------
    always_comb begin
        set_flags = 7'h00;
        set_flags[4:0] = other_flags_set_i;
        set_flags[actirq_pkg::IRQ_CB1]   = other_flags_set_i[4] |
                                           cb1_fall;
        set_flags[actirq_pkg::IRQ_SHIFT] = other_flags_set_i[2] |
                                           shift_done;
        set_flags[actirq_pkg::IRQ_T1]    = t1_to;
        set_flags[actirq_pkg::IRQ_T2]    = t2_to && !shift_run_q;
        clr_flags = 7'h00;
        if (wr && bus_i.addr == actirq_pkg::REG_IFR) begin
            clr_flags = bus_i.data[6:0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ifr_q <= 7'h00;
        end else begin
            ifr_q <= (ifr_q & ~clr_flags) | set_flags;
        end
    end

    // ------------------------------------------------------------
    // read path and pins, all registered
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
        end else if (rd) begin
            if (bus_i.addr == actirq_pkg::REG_PORT_B) begin
                rdata_o <= latch_b_q;
            end else if (bus_i.addr == actirq_pkg::REG_AUX) begin
                rdata_o <= aux_mode_control_q;
            end else if (bus_i.addr == actirq_pkg::REG_DIR_B) begin
                rdata_o <= dir_b_q;
            end else if (bus_i.addr == actirq_pkg::REG_T1_LO) begin
                rdata_o <= t1_cnt_q[7:0];
            end else if (bus_i.addr == actirq_pkg::REG_T1_HI) begin
                rdata_o <= t1_cnt_q[15:8];
            end else if (bus_i.addr == actirq_pkg::REG_T2_LO) begin
                rdata_o <= t2_cnt_q[7:0];
            end else if (bus_i.addr == actirq_pkg::REG_T2_HI) begin
                rdata_o <= t2_cnt_q[15:8];
            end else if (bus_i.addr == actirq_pkg::REG_SHIFT) begin
                rdata_o <= shifter_q;
            end else if (bus_i.addr == actirq_pkg::REG_IFR) begin
                rdata_o <= {|(ifr_q & ier_q), ifr_q};
            end else if (bus_i.addr == actirq_pkg::REG_IER) begin
                rdata_o <= {1'b1, ier_q};
            end else begin
                rdata_o <= 8'h00;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            irq_n_o      <= 1'b1;
            port_b_out_o <= 8'h00;
            port_b_oe_o  <= 8'h00;
            cb1_o        <= 1'b1;
            cb1_oe_o     <= 1'b0;
            cb2_o        <= 1'b1;
            cb2_oe_o     <= 1'b0;
            cb1_prev_q   <= 1'b1;
            pb6_prev_q   <= 1'b1;
        end else begin
            // set and enable pairs gate the single request line
            irq_n_o <= !(|((ifr_q | set_flags) & ier_q));
            port_b_out_o <= port_b_output_reg_q;
            port_b_oe_o  <= dir_b_q;
            if (aux_mode_control_q[actirq_pkg::AUX_T1_PIN]) begin
                port_b_out_o[7] <= t1_pin_q;
                port_b_oe_o[7]  <= 1'b1;
            end
            cb1_o    <= sclk_q;
            cb1_oe_o <= (smode != actirq_pkg::SM_OFF) && !ext_mode;
            cb2_o    <= shifter_q[SHIFT_LEN-1];
            cb2_oe_o <= shift_out_mode;
            cb1_prev_q <= cb1_i;
            pb6_prev_q <= port_b_pins_i[6];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic t1_hi_wr;
    assign t1_hi_wr = wr && bus_i.addr == actirq_pkg::REG_T1_HI;
    sequence s_hi_write;
        t1_hi_wr;
    endsequence

    a_ifr_clear_one: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (wr && bus_i.addr == actirq_pkg::REG_IFR && bus_i.data[6]
         && !t1_to) |=> !ifr_q[6])
        else $error("flag not cleared by one");
    a_ifr_keep_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (ifr_q[5] && !(wr && bus_i.addr == actirq_pkg::REG_IFR
         && bus_i.data[5])) |=> ifr_q[5])
        else $error("flag lost without clear");
    a_set_beats_clr: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        t1_to |=> ifr_q[actirq_pkg::IRQ_T1])
        else $error("concurrent set lost");
    a_t1_start: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_hi_write |=> t1_run_q && !t1_pin_q)
        else $error("timer one did not start");
    a_t1_reload: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (t1_to && aux_mode_control_q[6] && !t1_hi_wr)
        |=> t1_cnt_q == $past(t1_latch_q))
        else $error("free run reload wrong");
    a_t1_toggle: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (t1_to && aux_mode_control_q[6] && !t1_hi_wr)
        |=> t1_pin_q != $past(t1_pin_q))
        else $error("pin did not toggle");
    a_oneshot_end: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (t1_to && !aux_mode_control_q[6] && !t1_hi_wr)
        |=> t1_pin_q && !t1_run_q)
        else $error("one shot did not end");
    a_irq_follows: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (|(ifr_q & ier_q)) |=> !irq_n_o)
        else $error("request not asserted");
    a_portb_read: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (rd && bus_i.addr == actirq_pkg::REG_PORT_B)
        |=> rdata_o == $past(latch_b_q))
        else $error("port b read not latch");
    a_latch_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (aux_mode_control_q[0] && ifr_q[4] && $past(ifr_q[4])
         && $past(aux_mode_control_q[0]))
        |-> $stable(latch_b_q))
        else $error("latch changed while frozen");
endmodule

// file: dv/actirq_host.sv
// host model: register reads and writes over the parallel bus
module actirq_host (
    input  wire logic              sys_clk_i,
    input  wire logic [7:0]        rdata_i,
    output actirq_pkg::actirq_bus_s bus_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial bus_o = '{sel: 1'b0, wr: 1'b0, addr: 4'h0, data: 8'h00};

    // one access then one idle cycle; released fields carry inverted
    // values so a design that samples them without sel is caught
    task automatic acc(input logic w, input logic [3:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        @(posedge sys_clk_i);
        bus_o <= '{sel: 1'b1, wr: w, addr: a, data: d};
        @(posedge sys_clk_i);
        bus_o <= '{sel: 1'b0, wr: ~w, addr: ~a, data: ~d};
        #1 q = rdata_i;
    endtask

    // the high byte write is what starts the countdown
    task automatic t1_start(input logic [7:0] lo, input logic [7:0] hi);
        logic [7:0] q;
        acc(1'b1, actirq_pkg::REG_T1_LO, lo, q);
        acc(1'b1, actirq_pkg::REG_T1_HI, hi, q);
    endtask
endmodule

// file: dv/aux_control_timer_irq_bench.sv
// bench: registers, modes, port b latch, flags, timers and shifter
module aux_control_timer_irq_bench;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic       w;
        logic [3:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } actirq_row_s;
    logic                    clk = 1'b0;
    logic                    rst_n = 1'b0;
    logic                    ext_cb1 = 1'b1;
    logic                    ext_cb2 = 1'b1;
    logic [7:0]              ext_pins = 8'h40;
    logic [4:0]              flag_set = 5'h00;
    actirq_pkg::actirq_bus_s bus;
    logic [7:0]              rdata, pb_out, pb_oe;
    logic                    cb1_o, cb1_oe, cb2_o, cb2_oe, irq_n;
    logic                    pb7_q = 1'b1;
    logic [7:0]              sq;
    int                      miscompares = 0;
    int                      compares = 0;
    int                      cyc = 0;
    int                      n0, p;
    int                      periods[$];
    // rows: write flag, offset, write data, expected read
    actirq_row_s             rows[15] = '{
        '{1'b0, 4'hb, 8'h00, 8'h00}, '{1'b0, 4'he, 8'h00, 8'h80},
        '{1'b0, 4'hd, 8'h00, 8'h00}, '{1'b1, 4'hb, 8'h21, 8'h00},
        '{1'b0, 4'hb, 8'h00, 8'h21}, '{1'b1, 4'h2, 8'ha5, 8'h00},
        '{1'b0, 4'h2, 8'h00, 8'ha5}, '{1'b1, 4'he, 8'h83, 8'h00},
        '{1'b0, 4'he, 8'h00, 8'h83}, '{1'b1, 4'he, 8'h01, 8'h00},
        '{1'b0, 4'he, 8'h00, 8'h82}, '{1'b1, 4'hc, 8'hff, 8'h00},
        '{1'b0, 4'hc, 8'h00, 8'h00}, '{1'b1, 4'hd, 8'h80, 8'h00},
        '{1'b0, 4'hd, 8'h00, 8'h00}};

    always #2.5 clk = ~clk;

    actirq_top i_actirq_top (
        .sys_clk_i         (clk),
        .rst_n_i           (rst_n),
        .bus_i             (bus),
        .rdata_o           (rdata),
        .port_b_pins_i     ((pb_oe & pb_out) | (~pb_oe & ext_pins)),
        .port_b_out_o      (pb_out),
        .port_b_oe_o       (pb_oe),
        .cb1_i             (cb1_oe ? cb1_o : ext_cb1),
        .cb1_o             (cb1_o),
        .cb1_oe_o          (cb1_oe),
        .cb2_i             (cb2_oe ? cb2_o : ext_cb2),
        .cb2_o             (cb2_o),
        .cb2_oe_o          (cb2_oe),
        .other_flags_set_i (flag_set),
        .irq_n_o           (irq_n)
    );
    actirq_host i_actirq_host (
        .sys_clk_i (clk),
        .rdata_i   (rdata),
        .bus_o     (bus)
    );

    // cycles between changes of the timer one pin
    always @(posedge clk) begin
        cyc <= cyc + 1;
        pb7_q <= pb_out[7];
        if (pb_out[7] !== pb7_q) begin
            periods.push_back(cyc);
            cyc <= 1;
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        i_actirq_host.acc(1'b1, a, d, q);
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] e,
                        input logic [7:0] m = 8'hff);
        logic [7:0] q;
        i_actirq_host.acc(1'b0, a, 8'h00, q);
        chk(q & m, e);
    endtask
    // polls the flag register, bounded
    task automatic wait_flag(input int b, input int lim);
        logic [7:0] q;
        for (int n = 0; n < lim; n++) begin
            i_actirq_host.acc(1'b0, actirq_pkg::REG_IFR, 8'h00, q);
            if (q[b] === 1'b1) break;
        end
        chk(q & (8'h01 << b), 8'h01 << b);
    endtask
    task automatic wait_per(input int k);
        for (int n = 0; n < 200 && periods.size() < k; n++) @(posedge clk);
        #1;
        chk({7'h00, periods.size() >= k}, 8'h01);
    endtask
    task automatic fpulse(input logic [4:0] v);
        @(posedge clk);
        flag_set <= v;
        @(posedge clk);
        flag_set <= 5'h00;
    endtask
    // data is set up a cycle ahead and held well past the falling edge
    task automatic cb1_pulse(input logic b);
        @(posedge clk);
        ext_cb2 <= b;
        @(posedge clk);
        ext_cb1 <= 1'b0;
        repeat (3) @(posedge clk);
        ext_cb1 <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    task automatic pb6_pulse();
        @(posedge clk);
        ext_pins[6] <= 1'b0;
        repeat (3) @(posedge clk);
        ext_pins[6] <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    task automatic print_verdict();
        if (miscompares == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // well above the few hundred cycles the sequence needs
    initial begin
        #250000;
        miscompares++;
        print_verdict();
    end

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk({7'h00, irq_n}, 8'h01);
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            else rchk(rows[i].a, rows[i].e);
        end
        for (int m = 0; m < 8; m++) begin
            wr(actirq_pkg::REG_AUX, 8'(m << 2));
            repeat (2) @(posedge clk);
            #1;
            chk({cb1_oe, cb2_oe}, {m inside {1, 2, 4, 5, 6}, m[2]});
        end
        // latching: inputs from pins, outputs from the output register
        wr(actirq_pkg::REG_AUX, 8'h01);
        wr(actirq_pkg::REG_DIR_B, 8'hf0);
        wr(actirq_pkg::REG_PORT_B, 8'ha5);
        ext_pins <= 8'h7c;
        repeat (3) @(posedge clk);
        rchk(actirq_pkg::REG_PORT_B, 8'hac);
        cb1_pulse(1'b1);
        ext_pins <= 8'h40;
        repeat (3) @(posedge clk);
        rchk(actirq_pkg::REG_IFR, 8'h10);
        rchk(actirq_pkg::REG_PORT_B, 8'hac);
        wr(actirq_pkg::REG_IFR, 8'h10);
        repeat (3) @(posedge clk);
        rchk(actirq_pkg::REG_PORT_B, 8'ha0);
        wr(actirq_pkg::REG_DIR_B, 8'h00);
        // each of the five other_flags_set_i sources alone reaches the one request line
        wr(actirq_pkg::REG_IER, 8'h9f);
        for (int i = 0; i < 5; i++) begin
            fpulse(5'(1 << i));
            repeat (2) @(posedge clk);
            #1;
            chk({7'h00, irq_n}, 8'h00);
            rchk(actirq_pkg::REG_IFR, 8'h80 | 8'(1 << i));
            wr(actirq_pkg::REG_IFR, 8'(1 << i));
            repeat (2) @(posedge clk);
            #1;
            chk({7'h00, irq_n}, 8'h01);
        end
        // a set arriving with a write of zero to its bit survives
        fpulse(5'h02);
        fork
            wr(actirq_pkg::REG_IFR, 8'h02);
            fpulse(5'h01);
        join
        rchk(actirq_pkg::REG_IFR, 8'h81);
        wr(actirq_pkg::REG_IFR, 8'h7f);
        wr(actirq_pkg::REG_IER, 8'h7f);
        // timer one one-shot with pin output: low for latch+1 cycles
        wr(actirq_pkg::REG_AUX, 8'h80);
        wr(actirq_pkg::REG_T1L_HI, 8'h00);
        i_actirq_host.t1_start(8'h03, 8'h00);
        for (int n = 0; n < 10 && pb_out[7] !== 1'b0; n++) begin
            @(posedge clk);
            #1;
        end
        p = 0;
        while (pb_out[7] === 1'b0 && p < 40) begin
            @(posedge clk);
            #1;
            p++;
        end
        chk(8'(p), 8'h04);
        chk(pb_oe & 8'h80, 8'h80);
        rchk(actirq_pkg::REG_IFR, 8'h40, 8'h40);
        n0 = periods.size();
        repeat (30) @(posedge clk);
        chk(8'(periods.size() - n0), 8'h00);
        // free run: even spacing, latch write affects the period after next
        wr(actirq_pkg::REG_AUX, 8'hc0);
        n0 = periods.size();
        i_actirq_host.t1_start(8'h03, 8'h00);
        wait_per(n0 + 4);
        chk(8'(periods[n0 + 3]), 8'(periods[n0 + 2]));
        p = periods[periods.size() - 1];
        wr(actirq_pkg::REG_T1L_LO, 8'h07);
        n0 = periods.size();
        wait_per(n0 + 3);
        chk(8'(periods[n0]), 8'(p));
        chk(8'(periods[n0 + 1]), 8'(p));
        chk(8'(periods[n0 + 2]), 8'(p + 4));
        // timer two interval, then pulse counting on pin six
        wr(actirq_pkg::REG_AUX, 8'h00);
        wr(actirq_pkg::REG_IFR, 8'h7f);
        wr(actirq_pkg::REG_T2_LO, 8'h05);
        wr(actirq_pkg::REG_T2_HI, 8'h00);
        wait_flag(5, 10);
        wr(actirq_pkg::REG_AUX, 8'h20);
        wr(actirq_pkg::REG_IFR, 8'h20);
        wr(actirq_pkg::REG_T2_LO, 8'h02);
        wr(actirq_pkg::REG_T2_HI, 8'h00);
        repeat (20) @(posedge clk);
        pb6_pulse();
        rchk(actirq_pkg::REG_IFR, 8'h00, 8'h20);
        pb6_pulse();
        wait_flag(5, 4);
        // shift out on the system clock recirculates the byte
        wr(actirq_pkg::REG_AUX, 8'h18);
        wr(actirq_pkg::REG_IFR, 8'h7f);
        wr(actirq_pkg::REG_SHIFT, 8'h81);
        for (int b = 0; b < 8; b++) begin
            @(posedge clk);
            #1;
            sq = {sq[6:0], cb2_o};
        end
        chk(sq, 8'h81);
        wait_flag(2, 10);
        rchk(actirq_pkg::REG_SHIFT, 8'h81);
        // shift in on external clock, msb first
        wr(actirq_pkg::REG_AUX, 8'h0c);
        wr(actirq_pkg::REG_SHIFT, 8'h00);
        wr(actirq_pkg::REG_IFR, 8'h7f);
        for (int b = 7; b >= 0; b--) cb1_pulse(1'(8'ha5 >> b));
        wait_flag(2, 10);
        rchk(actirq_pkg::REG_IFR, 8'h14, 8'h14);
        rchk(actirq_pkg::REG_SHIFT, 8'ha5);
        print_verdict();
    end
endmodule
